/* pieb_pkg.sv */
// Package for the peripheral interrupt enable bank.
// Assumes an AXI4-Lite slave with 32-bit data and word-aligned registers.
package pieb_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_ENABLE_4 = 4'h0;  // peripheral_irq_enable_4
  localparam logic [3:0] OFS_ENABLE_5 = 4'h4;  // peripheral_irq_enable_5
  localparam logic [3:0] OFS_CONTROL  = 4'h8;  // interrupt_control_reg
  localparam logic [3:0] OFS_STATUS   = 4'hc;  // Pending and request view

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_LC4    = 7;
  localparam int BIT_LC3    = 6;
  localparam int BIT_LC2    = 5;
  localparam int BIT_LC1    = 4;
  localparam int BIT_TG     = 0;
  localparam int BIT_CC2    = 1;
  localparam int BIT_CC1    = 0;
  localparam int BIT_GPIE   = 6;  // Global peripheral enable in control
  localparam int BIT_STREQ  = 8;  // Gated request in status

  // ----------------------------------------------------------------------
  // Writable masks, reset values and response codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] MASK_EN4  = 8'hf1;
  localparam logic [7:0] MASK_EN5  = 8'h03;
  localparam logic [7:0] RST_EN    = 8'h00;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* pieb_enable_bank.sv */
// Peripheral interrupt enable bank: two mask registers, a global gate,
// and the gated request toward the core, behind an AXI4-Lite slave.
// Assumes flags come from peripheral logic on aclk.
//
// Notes on behaviour
// - Mask 4 bits 7..4 enable logic cells 4..1, each for its own cell.
// - An enable of one passes its flag, an enable of zero blocks it.
// - Mask 4 bit 0 gates the timer; bits 3..1 read zero; all reset zero.
// - Mask 5 bits 1,0 enable capture units 2,1; rest read zero; reset 0.
// - Nothing reaches the core unless the global peripheral enable is set.
`timescale 1ns/1ps
module pieb_enable_bank (
  input  wire logic        aclk,            // System clock, 25 MHz
  input  wire logic        aresetn,         // Synchronous reset, low
  input  wire logic [3:0]  logic_cell_flag, // Cell flags, [3] is cell 4
  input  wire logic        timer_gate_flag, // Timer gate acquisition flag
  input  wire logic [1:0]  capcmp_flag,     // Capture unit flags, [1] is 2
  input  wire logic [3:0]  s_axi_awaddr,    // Write address
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  output logic [1:0]       s_axi_bresp,     // Write response
  output logic             s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [3:0]  s_axi_araddr,    // Read address
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  output logic             periph_irq       // Gated request to the core
);

  // ----------------------------------------------------------------------
  // Request gating
  // ----------------------------------------------------------------------
  logic [7:0] enable_4;
  logic [7:0] enable_5;
  logic       global_peripheral_irq_en;
  logic [7:0] next_enable_4;
  logic [7:0] next_enable_5;
  logic       next_global_en;
  logic [6:0] req_vec;
  logic       any_req;
  logic       next_irq;

  // Gate each flag by its own enable only
  always_comb begin
    req_vec[3] = logic_cell_flag[3] & enable_4[pieb_pkg::BIT_LC4];
    req_vec[2] = logic_cell_flag[2] & enable_4[pieb_pkg::BIT_LC3];
    req_vec[1] = logic_cell_flag[1] & enable_4[pieb_pkg::BIT_LC2];
    req_vec[0] = logic_cell_flag[0] & enable_4[pieb_pkg::BIT_LC1];
    req_vec[4] = timer_gate_flag & enable_4[pieb_pkg::BIT_TG];
    req_vec[6] = capcmp_flag[1] & enable_5[pieb_pkg::BIT_CC2];
    req_vec[5] = capcmp_flag[0] & enable_5[pieb_pkg::BIT_CC1];
    any_req    = |req_vec;
    next_irq   = any_req & global_peripheral_irq_en;
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic        aw_held, w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_held, next_w_held;
  logic [3:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        do_write;

  // Read mux; unimplemented bits come back as zero
  function automatic logic [31:0] read_word(input logic [3:0] a,
                                            output logic ok);
    logic [31:0] v;
    v  = 32'h0000_0000;
    ok = 1'b1;
    unique case (a)
      pieb_pkg::OFS_ENABLE_4: v[7:0] = enable_4 & pieb_pkg::MASK_EN4;
      pieb_pkg::OFS_ENABLE_5: v[7:0] = enable_5 & pieb_pkg::MASK_EN5;
      pieb_pkg::OFS_CONTROL:  v[pieb_pkg::BIT_GPIE] = global_peripheral_irq_en;
      pieb_pkg::OFS_STATUS: begin
        v[6:0] = req_vec;
        v[pieb_pkg::BIT_STREQ] = periph_irq;
      end
      default: ok = 1'b0;
    endcase
    return v;
  endfunction

  // Next state of channels and registers
  always_comb begin
    logic rd_ok;
    rd_ok         = 1'b0;
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bvalid   = s_axi_bvalid;
    next_bresp    = s_axi_bresp;
    next_rvalid   = s_axi_rvalid;
    next_rresp    = s_axi_rresp;
    next_rdata    = s_axi_rdata;
    next_enable_4 = enable_4;
    next_enable_5 = enable_5;
    next_global_en = global_peripheral_irq_en;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = {s_axi_awaddr[3:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_held && w_held && !s_axi_bvalid;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = pieb_pkg::RESP_OK;
      // Only lane 0 carries register bits; other lanes are ignored
      if (w_strb[0]) begin
        unique case (aw_addr)
          pieb_pkg::OFS_ENABLE_4:
            next_enable_4 = w_data[7:0] & pieb_pkg::MASK_EN4;
          pieb_pkg::OFS_ENABLE_5:
            next_enable_5 = w_data[7:0] & pieb_pkg::MASK_EN5;
          pieb_pkg::OFS_CONTROL:
            next_global_en = w_data[pieb_pkg::BIT_GPIE];
          default: next_bresp = pieb_pkg::RESP_OK;
        endcase
      end
      if (aw_addr == pieb_pkg::OFS_STATUS) begin
        next_bresp = pieb_pkg::RESP_SLVERR; // Status is read only
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rdata  = read_word({s_axi_araddr[3:2], 2'b00}, rd_ok);
      next_rresp  = rd_ok ? pieb_pkg::RESP_OK : pieb_pkg::RESP_SLVERR;
      next_rvalid = 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Register stage; every reset clears the enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pieb_pkg::RESP_OK;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= pieb_pkg::RESP_OK;
      s_axi_rdata   <= 32'h0000_0000;
      enable_4      <= pieb_pkg::RST_EN;
      enable_5      <= pieb_pkg::RST_EN;
      global_peripheral_irq_en <= 1'b0;
      periph_irq    <= 1'b0;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      // Ready for one beat only when the holding slot is empty
      s_axi_awready <= !next_aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !next_w_held && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
      enable_4      <= next_enable_4;
      enable_5      <= next_enable_5;
      global_peripheral_irq_en <= next_global_en;
      periph_irq    <= next_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence seq_gate_off;
    !global_peripheral_irq_en;
  endsequence

  AST_GLOBAL_GATE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    seq_gate_off |=> !periph_irq)
    else $error("Request passed with global enable clear");
  AST_CELL4_BLOCK: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!enable_4[7] && logic_cell_flag[3]) |-> !req_vec[3])
    else $error("Cell 4 request passed while disabled");
  AST_OR_TREE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (global_peripheral_irq_en && req_vec != 7'h00) |=> periph_irq)
    else $error("Enabled request not forwarded");
  AST_PASS_ONE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (enable_5[0] && capcmp_flag[0]) |-> req_vec[5])
    else $error("Enabled capture 1 flag blocked");
  AST_EN4_ZERO: assert property (
    @(posedge aclk) disable iff (!aresetn)
    enable_4[3:1] == 3'h0)
    else $error("Unimplemented mask 4 bits set");
  AST_EN5_ZERO: assert property (
    @(posedge aclk) disable iff (!aresetn)
    enable_5[7:2] == 6'h00)
    else $error("Unimplemented mask 5 bits set");
  AST_RESET_CLR: assert property (
    @(posedge aclk)
    !aresetn |=> (enable_4 == 8'h00 && enable_5 == 8'h00 && !periph_irq))
    else $error("Enables not cleared by reset");
  AST_TIMER_GATE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (timer_gate_flag && enable_4[0] && global_peripheral_irq_en)
    |=> periph_irq)
    else $error("Timer gate request lost");
endmodule

/* pieb_enable_bank_test.sv */
// Self-checking bench for the peripheral interrupt enable bank.
// Assumes one 25 MHz clock and drives the AXI4-Lite port and the flags.
`timescale 1ns/1ps
module pieb_enable_bank_test;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  lc_flag = 4'h0;
  logic        tg_flag = 1'b0;
  logic [1:0]  cc_flag = 2'h0;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          err_count = 0;
  int          cmp_count = 0;
  int          seed = 32'h906f;
  int          m4 = 0;
  int          m5 = 0;
  int          mg = 0;

  always #20 aclk = ~aclk;

  pieb_enable_bank i_pieb_enable_bank (
    .aclk(aclk), .aresetn(aresetn), .logic_cell_flag(lc_flag),
    .timer_gate_flag(tg_flag), .capcmp_flag(cc_flag),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .periph_irq(irq));

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic stop_test;
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  // Bounded edge wait, so a stuck handshake ends the run
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 100) begin
      err_count++;
      stop_test();
    end
  endtask
  // Holds each valid until its own ready, bready until bvalid
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      tick(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp,
                        input logic [31:0] mask);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      tick(n);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk_word(rdata & mask, exp & mask);
    chk_word(32'(rresp), 32'(pieb_pkg::RESP_OK));  // Every word is mapped
  endtask
  // Write, check the response, and update the model
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] s);
    logic [1:0] rsp;
    axi_wr(a, d, s, rsp);
    if (a == pieb_pkg::OFS_STATUS)
      chk_word(32'(rsp), 32'(pieb_pkg::RESP_SLVERR));
    else
      chk_word(32'(rsp), 32'(pieb_pkg::RESP_OK));
    if (s[0] && a == pieb_pkg::OFS_ENABLE_4) m4 = d[7:0] & 8'hf1;
    if (s[0] && a == pieb_pkg::OFS_ENABLE_5) m5 = d[1:0];
    if (s[0] && a == pieb_pkg::OFS_CONTROL) mg = d[6];
  endtask
  // Model of the gated requests: cells 4..1, timer gate, capture 1, 2
  function automatic logic [6:0] model_req();
    return {cc_flag[1] & m5[1], cc_flag[0] & m5[0], tg_flag & m4[0],
            lc_flag & m4[7:4]};
  endfunction
  // Status view: requests in 6:0, gated request to the core in bit 8
  function automatic logic [31:0] status_exp();
    logic [6:0] r;
    r = model_req();
    return {23'h0, |r & mg[0], 1'b0, r};
  endfunction
  // Request leaves one edge after its inputs; two edges leave margin
  task automatic chk_path;
    logic e;
    repeat (2) @(posedge aclk);
    e = |model_req();
    chk_irq(irq, e & mg[0]);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(pieb_pkg::OFS_ENABLE_4, 32'h0, 32'hffffffff);
    rd_chk(pieb_pkg::OFS_ENABLE_5, 32'h0, 32'hffffffff);
    reg_wr(pieb_pkg::OFS_CONTROL, 32'h40, 4'hf);
    lc_flag <= 4'hf;
    tg_flag <= 1'b1;
    cc_flag <= 2'h3;
    chk_path();
    // One enable at a time with every flag high: only its own source passes
    for (int i = 0; i < 16; i++) begin
      reg_wr(pieb_pkg::OFS_ENABLE_4, (i < 8) ? 32'h1 << i : 32'h0, 4'h1);
      reg_wr(pieb_pkg::OFS_ENABLE_5, (i < 8) ? 32'h0 : 32'h1 << (i - 8), 4'h1);
      chk_path();
      rd_chk(pieb_pkg::OFS_STATUS, status_exp(), 32'h1ff);
    end
    reg_wr(pieb_pkg::OFS_ENABLE_4, 32'hffffffff, 4'hf);
    reg_wr(pieb_pkg::OFS_ENABLE_4, 32'h0, 4'he);
    reg_wr(pieb_pkg::OFS_STATUS, 32'hffffffff, 4'hf);
    rd_chk(pieb_pkg::OFS_ENABLE_4, 32'hf1, 32'hffffffff);
    reg_wr(pieb_pkg::OFS_CONTROL, 32'h0, 4'hf);
    chk_path();
    // Random masks, strobes, gate and flags against the model
    for (int k = 0; k < 40; k++) begin
      reg_wr(pieb_pkg::OFS_ENABLE_4, $random(seed), 4'($random(seed)));
      reg_wr(pieb_pkg::OFS_ENABLE_5, $random(seed), 4'($random(seed)));
      reg_wr(pieb_pkg::OFS_CONTROL, $random(seed), 4'hf);
      lc_flag <= 4'($random(seed));
      tg_flag <= 1'($random(seed));
      cc_flag <= 2'($random(seed));
      chk_path();
      rd_chk(pieb_pkg::OFS_STATUS, status_exp(), 32'h1ff);
      rd_chk(pieb_pkg::OFS_ENABLE_4, m4, 32'hffffffff);
      rd_chk(pieb_pkg::OFS_ENABLE_5, m5, 32'hffffffff);
      rd_chk(pieb_pkg::OFS_CONTROL, mg << 6, 32'h40);
    end
    // Mid-run reset with everything enabled must clear masks and gate
    reg_wr(pieb_pkg::OFS_ENABLE_4, 32'hff, 4'h1);
    reg_wr(pieb_pkg::OFS_ENABLE_5, 32'h3, 4'h1);
    reg_wr(pieb_pkg::OFS_CONTROL, 32'h40, 4'hf);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    m4 = pieb_pkg::RST_EN;
    m5 = pieb_pkg::RST_EN;
    mg = 0;
    rd_chk(pieb_pkg::OFS_ENABLE_4, 32'h0, 32'hffffffff);
    rd_chk(pieb_pkg::OFS_ENABLE_5, 32'h0, 32'hffffffff);
    rd_chk(pieb_pkg::OFS_CONTROL, 32'h0, 32'h40);
    chk_path();
    rd_chk(pieb_pkg::OFS_STATUS, status_exp(), 32'h1ff);
    stop_test();
  end
endmodule
